// ### include/iep_pkg.sv
package iep_pkg;

  // bus geometry
  localparam int unsigned ADDR_W       = 5;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned REG_W        = 16;

  // register byte offsets
  localparam logic [4:0]  OFS_ENABLE2  = 5'h00;
  localparam logic [4:0]  OFS_PRIO0    = 5'h04;
  localparam logic [4:0]  OFS_PRIO1    = 5'h08;
  localparam logic [4:0]  OFS_PRIO2    = 5'h0C;
  localparam logic [4:0]  OFS_PRIO3    = 5'h10;
  localparam logic [4:0]  OFS_FLAG2    = 5'h14;

  // implemented bits and reset values
  localparam logic [15:0] ENABLE2_MASK = 16'h07E1;
  localparam logic [15:0] ENABLE2_RST  = 16'h0000;
  localparam logic [15:0] FLAG2_RST    = 16'h0000;
  localparam logic [15:0] PRIO0_MASK   = 16'h7777;
  localparam logic [15:0] PRIO1_MASK   = 16'h7770;
  localparam logic [15:0] PRIO2_MASK   = 16'h7777;
  localparam logic [15:0] PRIO3_MASK   = 16'h0777;
  localparam logic [15:0] PRIO0_RST    = 16'h4444;
  localparam logic [15:0] PRIO1_RST    = 16'h4440;
  localparam logic [15:0] PRIO2_RST    = 16'h4444;
  localparam logic [15:0] PRIO3_RST    = 16'h0444;

  // field positions
  localparam int unsigned ADC_PAIRS    = 6;
  localparam int unsigned ADC_PAIR_LSB = 5;
  localparam int unsigned CMP4_BIT     = 0;
  localparam int unsigned PRIO_BANKS   = 4;
  localparam int unsigned FIELD_STRIDE = 4;
  localparam int unsigned LEVEL_W      = 3;

  // arbitration slots: four nibble slots per priority bank
  localparam int unsigned SLOTS        = 16;
  localparam int unsigned SLOT_W       = 4;
  localparam logic [2:0]  LEVEL_OFF    = 3'h0;
  localparam logic [2:0]  LEVEL_TOP    = 3'h7;

  typedef logic [2:0] iep_level_t;

endpackage

// ### include/iep_arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface iep_arb_if;
  import iep_pkg::*;
  logic [SLOTS-1:0]              req;
  logic [SLOTS-1:0][LEVEL_W-1:0] level;
  logic                          win_valid;
  logic [LEVEL_W-1:0]            win_level;
  logic [SLOT_W-1:0]             win_slot;

  modport arbiter (input req, input level, output win_valid, output win_level, output win_slot);
  modport owner (output req, output level, input win_valid, input win_level, input win_slot);
endinterface
`default_nettype wire

// ### verilog/iep_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module iep_arbiter (
  // request side and winner
  iep_arb_if.arbiter arb
);
  import iep_pkg::*;

  logic [SLOTS-1:0][LEVEL_W-1:0] eff;
  logic [LEVEL_W-1:0]            best_l;
  logic [SLOT_W-1:0]             best_s;

  // a slot without a request competes at level zero, i.e. not at all
  for (genvar g = 0; g < SLOTS; g++) begin : g_eff
    assign eff[g] = arb.req[g] ? arb.level[g] : LEVEL_OFF;
  end

  // strict compare keeps the lowest slot on a tie
  always_comb begin
    best_l = LEVEL_OFF;
    best_s = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (eff[i] > best_l) begin
        best_l = eff[i];
        best_s = SLOT_W'(i);
      end
    end
  end

  assign arb.win_valid = (best_l != LEVEL_OFF);
  assign arb.win_level = best_l;
  assign arb.win_slot  = best_s;

endmodule
`default_nettype wire

// ### verilog/iep_regs.sv
`timescale 1ns/1ps
`default_nettype none
module iep_regs (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  // avalon-mm slave
  input  wire logic [iep_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [iep_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic [iep_pkg::DATA_W-1:0]     avs_readdata,
  output logic                           avs_waitrequest,
  // events of the enable-bank sources
  input  wire logic [iep_pkg::ADC_PAIRS-1:0] adc_pair_done,
  input  wire logic                      comparator4_event,
  // flags and enables of the prioritised slots
  input  wire logic [iep_pkg::SLOTS-1:0] slot_flag,
  input  wire logic [iep_pkg::SLOTS-1:0] slot_enable,
  // qualified requests
  output logic [iep_pkg::ADC_PAIRS-1:0]  adc_pair_done_req,
  output logic                           comparator4_req,
  // arbitration result
  output logic                           irq_valid,
  output logic [iep_pkg::LEVEL_W-1:0]    irq_level,
  output logic [iep_pkg::SLOT_W-1:0]     irq_slot
);
  import iep_pkg::*;

  typedef struct packed {
    logic                          ack;
    logic [DATA_W-1:0]             rdata;
    logic [REG_W-1:0]              enable2;
    logic [REG_W-1:0]              flag2;
    logic [PRIO_BANKS-1:0][REG_W-1:0] prio;
    logic [ADC_PAIRS-1:0]          adc_req;
    logic                          cmp4_req;
    logic                          irq_valid;
    logic [LEVEL_W-1:0]            irq_level;
    logic [SLOT_W-1:0]             irq_slot;
  } iep_state_s;

  localparam logic [PRIO_BANKS-1:0][REG_W-1:0] PRIO_MASK =
    {PRIO3_MASK, PRIO2_MASK, PRIO1_MASK, PRIO0_MASK};
  localparam logic [PRIO_BANKS-1:0][REG_W-1:0] PRIO_RST =
    {PRIO3_RST, PRIO2_RST, PRIO1_RST, PRIO0_RST};

  iep_state_s st_q;
  iep_state_s st_d;
  iep_arb_if  arb ();

  logic             req_any;
  logic             commit_wr;
  logic [REG_W-1:0] lane_mask;
  logic [REG_W-1:0] wdata16;
  logic [REG_W-1:0] flag_set;
  logic [REG_W-1:0] flag_clr;
  logic [REG_W-1:0] rd_val;

  iep_arbiter u_arb (
    .arb (arb.arbiter)
  );

  // a slot's request is its flag qualified by its enable
  for (genvar g = 0; g < SLOTS; g++) begin : g_slot
    assign arb.req[g]   = slot_flag[g] & slot_enable[g];
    // field value is the level itself, 1..7, unsigned
    assign arb.level[g] = st_q.prio[g / FIELD_STRIDE][(g % FIELD_STRIDE) * FIELD_STRIDE +: LEVEL_W];
  end

  assign req_any   = avs_read | avs_write;
  // one wait state on every access; write lands when waitrequest drops
  assign commit_wr = avs_write & st_q.ack;
  assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata16   = avs_writedata[REG_W-1:0];

  always_comb begin
    flag_set = '0;
    flag_set[ADC_PAIR_LSB +: ADC_PAIRS] = adc_pair_done;
    flag_set[CMP4_BIT] = comparator4_event;
    flag_clr = '0;
    if (commit_wr && avs_address == OFS_FLAG2) begin
      flag_clr = wdata16 & lane_mask;
    end
  end

  always_comb begin
    case (avs_address)
      OFS_ENABLE2: rd_val = st_q.enable2;
      OFS_PRIO0:   rd_val = st_q.prio[0];
      OFS_PRIO1:   rd_val = st_q.prio[1];
      OFS_PRIO2:   rd_val = st_q.prio[2];
      OFS_PRIO3:   rd_val = st_q.prio[3];
      OFS_FLAG2:   rd_val = st_q.flag2;
      default:     rd_val = '0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.ack = req_any & ~st_q.ack;
    if (avs_read && !st_q.ack) begin
      st_d.rdata = {{(DATA_W-REG_W){1'b0}}, rd_val};
    end
    if (commit_wr && avs_address == OFS_ENABLE2) begin
      st_d.enable2 = ((st_q.enable2 & ~lane_mask) | (wdata16 & lane_mask))
                     & ENABLE2_MASK;
    end
    for (int b = 0; b < PRIO_BANKS; b++) begin
      if (commit_wr && avs_address == OFS_PRIO0 + 5'(b * 4)) begin
        st_d.prio[b] = ((st_q.prio[b] & ~lane_mask) | (wdata16 & lane_mask))
                       & PRIO_MASK[b];
      end
    end
    // a new event wins over a software clear in the same cycle
    st_d.flag2 = ((st_q.flag2 & ~flag_clr) | flag_set) & ENABLE2_MASK;
    st_d.adc_req = st_q.flag2[ADC_PAIR_LSB +: ADC_PAIRS]
                   & st_q.enable2[ADC_PAIR_LSB +: ADC_PAIRS];
    st_d.cmp4_req = st_q.flag2[CMP4_BIT] & st_q.enable2[CMP4_BIT];
    st_d.irq_valid = arb.win_valid;
    st_d.irq_level = arb.win_level;
    st_d.irq_slot  = arb.win_slot;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q         <= '0;
      st_q.enable2 <= ENABLE2_RST;
      st_q.flag2   <= FLAG2_RST;
      st_q.prio    <= PRIO_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_waitrequest   = ~st_q.ack;
  assign avs_readdata      = st_q.rdata;
  assign adc_pair_done_req = st_q.adc_req;
  assign comparator4_req   = st_q.cmp4_req;
  assign irq_valid         = st_q.irq_valid;
  assign irq_level         = st_q.irq_level;
  assign irq_slot          = st_q.irq_slot;

  // checking helpers
  logic             higher_exists;
  logic [LEVEL_W-1:0] win_field;

  always_comb begin
    higher_exists = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      if (arb.req[i] && arb.level[i] != LEVEL_OFF) begin
        if (arb.level[i] > arb.win_level) begin
          higher_exists = 1'b1;
        end
        if (arb.level[i] == arb.win_level && SLOT_W'(i) < arb.win_slot) begin
          higher_exists = 1'b1;
        end
      end
    end
  end

  assign win_field = arb.level[arb.win_slot];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_full_write(logic [4:0] ofs);
    avs_write && !avs_waitrequest && avs_address == ofs && avs_byteenable[1:0] == 2'b11;
  endsequence

  sequence s_read_start;
    avs_read && avs_waitrequest;
  endsequence

  bus_answer_a: assert property (s_read_start |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("read not answered after one wait state");

  enable_gate_a: assert property (
    (st_q.flag2[ADC_PAIR_LSB] && !st_q.enable2[ADC_PAIR_LSB]) |=> !adc_pair_done_req[0])
    else $error("disabled adc pair 0 request passed");

  enable_layout_a: assert property (
    s_full_write(OFS_ENABLE2) |=> st_q.enable2[10:5] == $past(avs_writedata[10:5]))
    else $error("adc pair enables not at bits 10..5");

  cmp4_pass_a: assert property (
    (st_q.flag2[CMP4_BIT] && st_q.enable2[CMP4_BIT]) |=> comparator4_req)
    else $error("enabled comparator 4 request blocked");

  unimpl_zero_a: assert property (
    (st_q.enable2 & ~ENABLE2_MASK) == '0 && (st_q.prio[1] & ~PRIO1_MASK) == '0
    && (st_q.prio[3] & ~PRIO3_MASK) == '0)
    else $error("unimplemented bit holds a one");

  level_value_a: assert property (
    arb.win_valid |=> irq_valid && irq_level == $past(win_field))
    else $error("presented level differs from field value");

  top_level_a: assert property (
    (arb.req[0] && arb.level[0] == LEVEL_TOP) |=> irq_level == LEVEL_TOP)
    else $error("level 7 request not presented at level 7");

  off_never_wins_a: assert property (
    arb.win_valid |-> arb.req[arb.win_slot] && win_field != LEVEL_OFF)
    else $error("disabled or unrequested slot won");

  reset_values_a: assert property (
    !$past(resetn) |-> st_q.enable2 == ENABLE2_RST && st_q.prio == PRIO_RST)
    else $error("wrong reset values");

  timer1_field_a: assert property (
    s_full_write(OFS_PRIO0) |=> arb.level[3] == $past(avs_writedata[14:12]))
    else $error("timer1 field not at bits 14..12");

  flag_set_wins_a: assert property (
    adc_pair_done[0] |=> st_q.flag2[ADC_PAIR_LSB])
    else $error("adc pair 0 event lost");

  winner_best_a: assert property (arb.win_valid |-> !higher_exists)
    else $error("winner is not the best slot");

endmodule
`default_nettype wire

// ### tb/iep_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module iep_src_model (
  // clock
  input  wire logic       core_clk,
  // command from the bench
  input  wire logic       fire,
  input  wire logic [6:0] which,
  // event pulses toward the block
  output logic [5:0]      adc_pair_done,
  output logic            comparator4_event
);
  initial begin
    adc_pair_done     = 6'h00;
    comparator4_event = 1'b0;
  end
  // pulses last one cycle, a held level would keep re-setting flags
  always @(posedge core_clk) begin
    adc_pair_done     <= fire ? which[6:1] : 6'h00;
    comparator4_event <= fire & which[0];
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import iep_pkg::*;
  logic               core_clk       = 1'b0;
  logic               resetn         = 1'b0;
  logic [ADDR_W-1:0]  avs_address    = '0;
  logic               avs_read       = 1'b0;
  logic               avs_write      = 1'b0;
  logic [DATA_W-1:0]  avs_writedata  = '0;
  logic [3:0]         avs_byteenable = 4'h0;
  logic [DATA_W-1:0]  avs_readdata;
  logic               avs_waitrequest;
  logic [SLOTS-1:0]   slot_flag      = '0;
  logic [SLOTS-1:0]   slot_enable    = '0;
  logic [5:0]         adc_pair_done;
  logic               comparator4_event;
  logic [5:0]         adc_pair_done_req;
  logic               comparator4_req;
  logic               irq_valid;
  logic [2:0]         irq_level;
  logic [3:0]         irq_slot;
  logic               fire           = 1'b0;
  logic [6:0]         which          = 7'h00;
  int                 n_errors       = 0;
  int                 checks_done    = 0;
  int                 cycles         = 0;
  logic [15:0]        rnd            = 16'h0004;
  logic [15:0]        prio [4];
  logic [15:0]        en;
  logic [31:0]        rd;
  logic [4:0]         ofs_t [5]      = '{OFS_ENABLE2, OFS_PRIO0, OFS_PRIO1, OFS_PRIO2, OFS_PRIO3};
  logic [15:0]        msk_t [5]      = '{ENABLE2_MASK, PRIO0_MASK, PRIO1_MASK, PRIO2_MASK, PRIO3_MASK};
  logic [15:0]        rst_t [5]      = '{ENABLE2_RST, PRIO0_RST, PRIO1_RST, PRIO2_RST, PRIO3_RST};

  always #10 core_clk = ~core_clk;

  iep_src_model u_iep_src_model (.core_clk(core_clk), .fire(fire), .which(which),
    .adc_pair_done(adc_pair_done), .comparator4_event(comparator4_event));

  iep_regs u_iep_regs (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .adc_pair_done(adc_pair_done),
    .comparator4_event(comparator4_event), .slot_flag(slot_flag), .slot_enable(slot_enable),
    .adc_pair_done_req(adc_pair_done_req), .comparator4_req(comparator4_req),
    .irq_valid(irq_valid), .irq_level(irq_level), .irq_slot(irq_slot));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // expected {valid, level, slot}: highest level, lowest slot on a tie
  function automatic logic [7:0] arb_exp(input logic [15:0] f, input logic [15:0] e,
                                         input logic [15:0] p [4]);
    logic [2:0] best;
    logic [3:0] slot;
    logic [2:0] lv;
    best = 3'h0;
    slot = 4'h0;
    for (int s = 0; s < 16; s++) begin
      lv = p[s / 4][(s % 4) * 4 +: 3];
      if (f[s] && e[s] && lv > best) begin
        best = lv;
        slot = s[3:0];
      end
    end
    return {best != 3'h0, best, slot};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one edge passes first so a released strobe is never re-raised in the same step
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge core_clk);
    avs_address    <= a;
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= be;
    // waitrequest and read data are judged at the rising edge, before it updates them
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ofs_t[i], 16'h0000, 4'h0, rd);
      chk("reset_value", rd, {16'h0000, rst_t[i]});
    end
    chk("irq_valid_reset", {31'h0, irq_valid}, 32'h0000_0000);
    bus(1'b1, 5'h18, 16'hFFFF, 4'hF, rd);
    bus(1'b0, 5'h18, 16'h0000, 4'h0, rd);
    chk("unmapped", rd, 32'h0000_0000);
    bus(1'b1, OFS_PRIO0, 16'hFFFF, 4'h2, rd);
    bus(1'b0, OFS_PRIO0, 16'h0000, 4'h0, rd);
    chk("upper_lane", rd, 32'h0000_7744);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ofs_t[i], 16'hFFFF, 4'h3, rd);
      bus(1'b0, ofs_t[i], 16'h0000, 4'h0, rd);
      chk("impl_bits", rd, {16'h0000, msk_t[i]});
    end
    for (int it = 0; it < 24; it++) begin
      for (int i = 0; i < 4; i++) begin
        rnd = lfsr(rnd);
        prio[i] = (it == 0) ? 16'h0000 : (it == 1) ? 16'h7777 & msk_t[i + 1] : rnd & msk_t[i + 1];
        bus(1'b1, ofs_t[i + 1], prio[i], 4'h3, rd);
      end
      bus(1'b0, ofs_t[it % 4 + 1], 16'h0000, 4'h0, rd);
      chk("prio_readback", rd, {16'h0000, prio[it % 4]});
      rnd = lfsr(rnd);
      en = rnd & ENABLE2_MASK;
      bus(1'b1, OFS_ENABLE2, en, 4'h3, rd);
      rnd = lfsr(rnd);
      slot_flag   <= (it < 2) ? 16'hFFFF : rnd;
      slot_enable <= (it < 2) ? 16'hFFFF : lfsr(rnd);
      which       <= rnd[6:0];
      fire        <= 1'b1;
      @(posedge core_clk);
      fire <= 1'b0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk("irq", {24'h0, irq_valid, irq_level, irq_slot},
          {24'h0, arb_exp(slot_flag, slot_enable, prio)});
      chk("adc_req", {26'h0, adc_pair_done_req}, {26'h0, which[6:1] & en[10:5]});
      chk("cmp4_req", {31'h0, comparator4_req}, {31'h0, which[0] & en[0]});
      bus(1'b0, OFS_FLAG2, 16'h0000, 4'h0, rd);
      chk("flags", rd, {21'h0, which[6:1], 4'h0, which[0]});
      bus(1'b1, OFS_FLAG2, 16'h07E1, 4'h3, rd);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk("req_cleared", {25'h0, adc_pair_done_req, comparator4_req}, 32'h0000_0000);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
